// ### hw/dpbm_pkg.sv
package dpbm_pkg;

  // Storage geometry, in port A write-width words
  localparam int BYTE_W = 9;
  localparam int LANES = 2;
  localparam int DATA_W = BYTE_W * LANES;
  localparam int DEPTH = 16;
  localparam int ADDR_W = 4;
  // Port A read side is twice the write width, half the depth
  localparam int RD_MULT = 2;
  localparam int RD_W = DATA_W * RD_MULT;
  localparam int RD_ADDR_W = ADDR_W - 1;

  // Output reset values, sized to each read width
  localparam logic [RD_W-1:0] RST_VAL_A = 36'h0_0000_ffff;
  localparam logic [DATA_W-1:0] RST_VAL_B = 18'h0_ffff;

  // Initial contents: table words from location 0, fill for the rest
  localparam int INIT_COUNT = 4;
  localparam logic [4*DATA_W-1:0] INIT_TABLE = 72'h00_00c2_0000_0400_0000;
  localparam logic [DATA_W-1:0] INIT_FILL = 18'h0_0000;

  // Memory configurations
  typedef enum {
    DPBM_SP_RAM,
    DPBM_SDP_RAM,
    DPBM_TDP_RAM,
    DPBM_SP_ROM,
    DPBM_DP_ROM
  } dpbm_mem_type_t;

  // Output behaviour during a write
  typedef enum {
    DPBM_READ_FIRST,
    DPBM_WRITE_FIRST,
    DPBM_NO_CHANGE
  } dpbm_mode_t;

  // Request side of one memory port
  typedef struct packed {
    logic clock_enable;
    logic [LANES-1:0] write_enable;
    logic output_sync_reset;
    logic final_reg_enable;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] write_data;
  } dpbm_port_req_t;

endpackage

// ### hw/dpbm_core.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Output path of one port: latch, optional memory-side and core-side stages
module dpbm_out_pipe #(
  parameter int W = 18,
  parameter bit PRIM_REG = 1'b1,
  parameter bit CORE_REG = 1'b0,
  parameter bit USE_FINAL_REG_ENABLE = 1'b0,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_en,
  input wire logic i_load,
  input wire logic i_ssr,
  input wire logic i_final_reg_enable,
  input wire logic [W-1:0] i_data,
  output logic [W-1:0] o_latch,
  output logic [W-1:0] o_data
);
  localparam bit HAS_STAGE = PRIM_REG | CORE_REG;

  logic [W-1:0] latch_reg;
  logic [W-1:0] prim_reg;
  logic [W-1:0] core_reg;
  wire fin_ce;
  wire [W-1:0] core_src;

  // Last stage enable: own enable only with a register stage
  assign fin_ce = (HAS_STAGE && USE_FINAL_REG_ENABLE) ? i_final_reg_enable : i_en;
  assign core_src = PRIM_REG ? prim_reg : latch_reg;

  // Latch: the final stage only when no registers follow
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      latch_reg <= RST;
    else if (!HAS_STAGE && i_en && i_ssr)
      latch_reg <= RST;
    else if (i_load)
      latch_reg <= i_data;
  end

  // Memory-side stage, one cycle of latency
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      prim_reg <= RST;
    else if (PRIM_REG && !CORE_REG && fin_ce)
      prim_reg <= i_ssr ? RST : latch_reg;
    else if (PRIM_REG && CORE_REG && i_en)
      prim_reg <= latch_reg;
  end

  // Core-side stage, one cycle of latency
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      core_reg <= RST;
    else if (CORE_REG && fin_ce)
      core_reg <= i_ssr ? RST : core_src;
  end

  // Output is whichever flop is last
  assign o_latch = latch_reg;
  assign o_data = CORE_REG ? core_reg : (PRIM_REG ? prim_reg : latch_reg);
endmodule

////////////////////////////////////////////////////////////////////////////////
// Memory core
module dpbm_core #(
  parameter dpbm_pkg::dpbm_mem_type_t MEM_TYPE = dpbm_pkg::DPBM_TDP_RAM,
  parameter dpbm_pkg::dpbm_mode_t MODE_A = dpbm_pkg::DPBM_READ_FIRST,
  parameter dpbm_pkg::dpbm_mode_t MODE_B = dpbm_pkg::DPBM_WRITE_FIRST,
  parameter bit USE_EN_A = 1'b1,
  parameter bit USE_EN_B = 1'b1,
  parameter bit USE_SSR_A = 1'b1,
  parameter bit USE_SSR_B = 1'b1,
  parameter bit PRIM_REG = 1'b1,
  parameter bit CORE_REG = 1'b0,
  parameter bit USE_FINAL_REG_ENABLE = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire dpbm_pkg::dpbm_port_req_t i_port_a,
  input wire dpbm_pkg::dpbm_port_req_t i_port_b,
  output logic [dpbm_pkg::RD_W-1:0] o_port_a_read_data,
  output logic [dpbm_pkg::DATA_W-1:0] o_port_b_read_data
);
  localparam int W = dpbm_pkg::DATA_W;
  localparam bit IS_RAM = (MEM_TYPE != dpbm_pkg::DPBM_SP_ROM)
    && (MEM_TYPE != dpbm_pkg::DPBM_DP_ROM);
  localparam bit IS_DUAL = (MEM_TYPE != dpbm_pkg::DPBM_SP_RAM)
    && (MEM_TYPE != dpbm_pkg::DPBM_SP_ROM);
  localparam bit A_READS = (MEM_TYPE != dpbm_pkg::DPBM_SDP_RAM);
  localparam bit B_WRITES = (MEM_TYPE == dpbm_pkg::DPBM_TDP_RAM);
  localparam bit HAS_STAGE = PRIM_REG | CORE_REG;

  // Byte-lane merge of a write into a stored word
  function automatic logic [W-1:0] merge(input logic [W-1:0] old_w,
    input logic [W-1:0] new_w, input logic [dpbm_pkg::LANES-1:0] we);
    logic [W-1:0] res;
    res = old_w;
    for (int l = 0; l < dpbm_pkg::LANES; l++)
    begin
      if (we[l])
        res[l*dpbm_pkg::BYTE_W +: dpbm_pkg::BYTE_W] =
          new_w[l*dpbm_pkg::BYTE_W +: dpbm_pkg::BYTE_W];
    end
    return res;
  endfunction

  // Initial word of a location
  function automatic logic [W-1:0] init_word(input int idx);
    logic [W-1:0] res;
    res = dpbm_pkg::INIT_FILL;
    if (idx < dpbm_pkg::INIT_COUNT)
      res = dpbm_pkg::INIT_TABLE[idx*W +: W];
    return res;
  endfunction

  logic [W-1:0] mem [0:dpbm_pkg::DEPTH-1];

  wire a_en;
  wire b_en;
  wire a_ssr;
  wire b_ssr;
  wire [dpbm_pkg::ADDR_W-1:0] a_addr;
  wire [dpbm_pkg::ADDR_W-1:0] b_addr;
  wire [dpbm_pkg::LANES-1:0] a_we;
  wire [dpbm_pkg::LANES-1:0] b_we;
  wire a_wr;
  wire b_wr;
  wire [dpbm_pkg::RD_ADDR_W-1:0] a_rd_idx;
  wire [dpbm_pkg::ADDR_W-1:0] a_lo_addr;
  wire [dpbm_pkg::ADDR_W-1:0] a_hi_addr;
  wire [W-1:0] a_lo_old;
  wire [W-1:0] a_hi_old;
  wire [W-1:0] a_lo_new;
  wire [W-1:0] a_hi_new;
  wire [dpbm_pkg::RD_W-1:0] a_old;
  wire [dpbm_pkg::RD_W-1:0] a_new;
  wire [dpbm_pkg::RD_W-1:0] a_latch_next;
  wire [W-1:0] b_old;
  wire [W-1:0] b_latch_next;
  wire a_load;
  wire b_load;
  wire a_fin_ce;
  wire b_fin_ce;
  wire [dpbm_pkg::RD_W-1:0] a_latch;
  wire [W-1:0] b_latch;

  // Port controls; absent enables read as always on
  assign a_en = USE_EN_A ? i_port_a.clock_enable : 1'b1;
  assign b_en = IS_DUAL && (USE_EN_B ? i_port_b.clock_enable : 1'b1);
  assign a_ssr = USE_SSR_A && i_port_a.output_sync_reset;
  assign b_ssr = USE_SSR_B && i_port_b.output_sync_reset;
  assign a_addr = i_port_a.address;
  assign b_addr = i_port_b.address;
  assign a_we = IS_RAM ? i_port_a.write_enable : '0;
  assign b_we = B_WRITES ? i_port_b.write_enable : '0;
  assign a_wr = a_en && (|a_we);
  assign b_wr = b_en && (|b_we);

  // Port A wide read: two write-width words, low word at even address
  assign a_rd_idx = a_addr[dpbm_pkg::ADDR_W-1:1];
  assign a_lo_addr = {a_rd_idx, 1'b0};
  assign a_hi_addr = {a_rd_idx, 1'b1};
  assign a_lo_old = mem[a_lo_addr];
  assign a_hi_old = mem[a_hi_addr];
  assign a_lo_new = (a_wr && !a_addr[0]) ? merge(a_lo_old, i_port_a.write_data, a_we) : a_lo_old;
  assign a_hi_new = (a_wr && a_addr[0]) ? merge(a_hi_old, i_port_a.write_data, a_we) : a_hi_old;
  assign a_old = {a_hi_old, a_lo_old};
  assign a_new = {a_hi_new, a_lo_new};

  // Port A latch source per write mode
  assign a_latch_next = (a_wr && MODE_A == dpbm_pkg::DPBM_WRITE_FIRST)
    ? a_new : a_old;
  assign a_load = A_READS && a_en
    && !(a_wr && MODE_A == dpbm_pkg::DPBM_NO_CHANGE);

  // Port B latch source; no-change is not offered on this port
  assign b_old = mem[b_addr];
  assign b_latch_next = (b_wr && MODE_B == dpbm_pkg::DPBM_WRITE_FIRST)
    ? merge(b_old, i_port_b.write_data, b_we) : b_old;
  assign b_load = b_en;

  // Last-stage enables, mirrored for checking
  assign a_fin_ce = (HAS_STAGE && USE_FINAL_REG_ENABLE) ? i_port_a.final_reg_enable : a_en;
  assign b_fin_ce = (HAS_STAGE && USE_FINAL_REG_ENABLE) ? i_port_b.final_reg_enable : b_en;

  // Array: initial image on reset, byte-lane writes; A wins a same-word clash
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (int i = 0; i < dpbm_pkg::DEPTH; i++)
        mem[i] <= init_word(i);
    end
    else
    begin
      if (b_wr)
        mem[b_addr] <= merge(mem[b_addr], i_port_b.write_data, b_we);
      if (a_wr)
        mem[a_addr] <= merge(mem[a_addr], i_port_a.write_data, a_we);
    end
  end

  // Output paths
  dpbm_out_pipe #(
    .W(dpbm_pkg::RD_W),
    .PRIM_REG(PRIM_REG),
    .CORE_REG(CORE_REG),
    .USE_FINAL_REG_ENABLE(USE_FINAL_REG_ENABLE),
    .RST(dpbm_pkg::RST_VAL_A)
  ) u_pipe_a (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_en(a_en && A_READS),
    .i_load(a_load),
    .i_ssr(a_ssr),
    .i_final_reg_enable(i_port_a.final_reg_enable && A_READS),
    .i_data(a_latch_next),
    .o_latch(a_latch),
    .o_data(o_port_a_read_data)
  );

  dpbm_out_pipe #(
    .W(W),
    .PRIM_REG(PRIM_REG),
    .CORE_REG(CORE_REG),
    .USE_FINAL_REG_ENABLE(USE_FINAL_REG_ENABLE),
    .RST(dpbm_pkg::RST_VAL_B)
  ) u_pipe_b (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_en(b_en),
    .i_load(b_load),
    .i_ssr(b_ssr),
    .i_final_reg_enable(i_port_b.final_reg_enable && IS_DUAL),
    .i_data(b_latch_next),
    .o_latch(b_latch),
    .o_data(o_port_b_read_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  chk_a_ssr_value: assert property (
    A_READS && a_fin_ce && a_ssr |=> o_port_a_read_data == dpbm_pkg::RST_VAL_A)
    else $error("port A output not at reset value");

  chk_b_final_hold: assert property (
    !b_fin_ce && HAS_STAGE |=> $stable(o_port_b_read_data))
    else $error("port B final stage moved without enable");

  chk_write_gate: assert property (
    !a_en |=> $stable(a_latch)
      && ($past(b_wr && b_addr == a_addr) || mem[$past(a_addr)] == $past(mem[a_addr])))
    else $error("port A acted while disabled");

  chk_rom_no_write: assert property (
    !IS_RAM |-> !a_wr && !b_wr)
    else $error("ROM accepted a write");

  chk_b_readonly: assert property (
    !B_WRITES |-> !b_wr)
    else $error("port B wrote outside true dual-port");

  chk_a_store: assert property (
    a_wr && (&a_we) |=> mem[$past(a_addr)] == $past(i_port_a.write_data))
    else $error("port A write not stored");

  chk_a_read_first: assert property (
    A_READS && a_wr && MODE_A == dpbm_pkg::DPBM_READ_FIRST
      && (HAS_STAGE || !a_ssr) |=> a_latch == $past(a_old))
    else $error("port A read-first showed wrong data");

  chk_a_no_change: assert property (
    a_wr && MODE_A == dpbm_pkg::DPBM_NO_CHANGE && (HAS_STAGE || !a_ssr)
      |=> $stable(a_latch))
    else $error("port A no-change output moved");

  chk_b_latency: assert property (
    PRIM_REG && !CORE_REG && b_fin_ce && !b_ssr
      |=> o_port_b_read_data == $past(b_latch))
    else $error("port B stage latency wrong");
endmodule

// ### verif/dpbm_user_model.sv
`timescale 1ns/10ps

////////////////////////////////////////
// User logic on both ports, one shared clock
module dpbm_user_model (
  input wire logic i_sys_clk,
  input wire dpbm_pkg::dpbm_port_req_t i_cmd_a,
  input wire dpbm_pkg::dpbm_port_req_t i_cmd_b,
  output dpbm_pkg::dpbm_port_req_t o_port_a = '0,
  output dpbm_pkg::dpbm_port_req_t o_port_b = '0
);
  // Disabled port shows inverted write data, so any stray write is visible
  function automatic dpbm_pkg::dpbm_port_req_t shape(input dpbm_pkg::dpbm_port_req_t c);
    dpbm_pkg::dpbm_port_req_t r;
    r = c;
    if (!c.clock_enable)
    begin
      r.write_data = ~c.write_data;
    end
    return r;
  endfunction

  // Launch both ports off the falling edge of the common clock
  always @(negedge i_sys_clk)
  begin
    o_port_a <= shape(i_cmd_a);
    o_port_b <= shape(i_cmd_b);
  end
endmodule

// ### verif/dpbm_core_tb_top.sv
`timescale 1ns/10ps

module dpbm_core_tb_top;
  typedef struct {
    dpbm_pkg::dpbm_port_req_t a;
    dpbm_pkg::dpbm_port_req_t b;
    logic [35:0] ea;
    logic [17:0] eb;
  } dpbm_row_t;

  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  dpbm_pkg::dpbm_port_req_t cmd_a = '0;
  dpbm_pkg::dpbm_port_req_t cmd_b = '0;
  dpbm_pkg::dpbm_port_req_t port_a;
  dpbm_pkg::dpbm_port_req_t port_b;
  logic [dpbm_pkg::RD_W-1:0] rd_a;
  logic [dpbm_pkg::DATA_W-1:0] rd_b;
  int miscompares = 0;
  int cmp_count = 0;
  dpbm_row_t rows[8];

  // 25 MHz clock
  always #20 i_sys_clk = ~i_sys_clk;

  ////////////////////////////////////////
  // Far side and memory
  dpbm_user_model i_dpbm_user_model (
    .i_sys_clk(i_sys_clk),
    .i_cmd_a(cmd_a),
    .i_cmd_b(cmd_b),
    .o_port_a(port_a),
    .o_port_b(port_b)
  );

  dpbm_core i_dpbm_core (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_port_a(port_a),
    .i_port_b(port_b),
    .o_port_a_read_data(rd_a),
    .o_port_b_read_data(rd_b)
  );

  ////////////////////////////////////////
  // Request builder, no output reset
  function automatic dpbm_pkg::dpbm_port_req_t rq(input logic en, input logic [1:0] we,
    input logic [3:0] ad, input logic [17:0] d);
    rq = '{en, we, 1'b0, 1'b1, ad, d};
  endfunction

  // Compare and count
  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Hand a request to the user model just after a rising edge
  task automatic drive(input dpbm_pkg::dpbm_port_req_t a, input dpbm_pkg::dpbm_port_req_t b);
    @(posedge i_sys_clk);
    cmd_a = a;
    cmd_b = b;
  endtask

  // Verdict
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (600) @(posedge i_sys_clk);
    miscompares++;
    summarize();
  end

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    dpbm_pkg::dpbm_port_req_t ra;
    dpbm_pkg::dpbm_port_req_t rb;
    rows[0] = '{rq(1, 2'h0, 4'h2, 18'h0), rq(1, 2'h0, 4'h1, 18'h0), 36'h0_000c_2000, 18'h0_0100};
    rows[1] = '{rq(1, 2'h3, 4'h5, 18'h2_abcd), rq(1, 2'h0, 4'h0, 18'h0), 36'h0, 18'h0};
    rows[2] = '{rq(1, 2'h0, 4'h4, 18'h0), rq(1, 2'h1, 4'h6, 18'h1_ff55), 36'ha_af34_0000,
      18'h0_0155};
    rows[3] = '{rq(1, 2'h2, 4'h7, 18'h3_fe55), rq(1, 2'h0, 4'h5, 18'h0), 36'h0_0000_0155,
      18'h2_abcd};
    rows[4] = '{rq(1, 2'h0, 4'h6, 18'h0), rq(1, 2'h0, 4'h7, 18'h0), 36'hf_f800_0155, 18'h3_fe00};
    rows[5] = '{rq(0, 2'h3, 4'h0, 18'h0), rq(0, 2'h3, 4'h1, 18'h0), 36'hf_f800_0155, 18'h3_fe00};
    rows[6] = '{rq(1, 2'h0, 4'h0, 18'h0), rq(1, 2'h0, 4'h1, 18'h0), 36'h0_0400_0000, 18'h0_0100};
    rows[7] = '{rq(1, 2'h3, 4'h3, 18'h1_2345), rq(1, 2'h0, 4'h3, 18'h0), 36'h0_000c_2000,
      18'h0_0003};
    repeat (10) @(negedge i_sys_clk);
    check("reset port a", rd_a, dpbm_pkg::RST_VAL_A);
    check("reset port b", {18'h0, rd_b}, {18'h0, dpbm_pkg::RST_VAL_B});
    i_arst_n = 1'b1;
    // Each row: request cycle, read-back cycle, then output after two edges
    foreach (rows[i])
    begin
      ra = rows[i].a;
      rb = rows[i].b;
      drive(ra, rb);
      ra.clock_enable = 1'b1;
      rb.clock_enable = 1'b1;
      ra.write_enable = '0;
      rb.write_enable = '0;
      drive(ra, rb);
      @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      check("row port a", rd_a, rows[i].ea);
      check("row port b", {18'h0, rd_b}, {18'h0, rows[i].eb});
    end
    // Output reset with enable lands on the last stage in one edge
    ra = rq(1, 2'h0, 4'h2, 18'h0);
    rb = rq(1, 2'h0, 4'h1, 18'h0);
    ra.output_sync_reset = 1'b1;
    rb.output_sync_reset = 1'b1;
    drive(ra, rb);
    drive(rq(1, 2'h0, 4'h2, 18'h0), rq(1, 2'h0, 4'h1, 18'h0));
    @(negedge i_sys_clk);
    check("ssr port a", rd_a, dpbm_pkg::RST_VAL_A);
    check("ssr port b", {18'h0, rd_b}, {18'h0, dpbm_pkg::RST_VAL_B});
    // Latch kept its read during the reset
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    check("after ssr a", rd_a, 36'h4_8d14_2000);
    check("after ssr b", {18'h0, rd_b}, 36'h0_0000_0100);
    // Output reset without enable does nothing
    ra.clock_enable = 1'b0;
    rb.clock_enable = 1'b0;
    drive(ra, rb);
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    check("gated ssr a", rd_a, 36'h4_8d14_2000);
    check("gated ssr b", {18'h0, rd_b}, 36'h0_0000_0100);
    summarize();
  end
endmodule
